// [hw/prs_pkg.sv]
// Shared constants and types of the photodiode array readout sequencer
`default_nettype none
package prs_pkg;

  // ****************************************************************
  // Array geometry and counter widths
  // ****************************************************************
  localparam int PIXEL_COUNT = 512;
  localparam int SCAN_CNT_W = 16;
  localparam int PERIOD_CNT_W = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int FAST_MIN_PERIOD_NS = 1000;
  localparam int SLOW_MIN_PERIOD_NS = 10000;
  localparam int SCAN_TIME_NS = 520000;
  localparam int FAST_MIN_PERIOD_CYC =
    (FAST_MIN_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SLOW_MIN_PERIOD_CYC =
    (SLOW_MIN_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic SCAN_DONE_N_RST = 1'b1;
  localparam logic INTEG_CLEAR_RST = 1'b0;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    PRS_IDLE,
    PRS_READ,
    PRS_DONE
  } prs_state_t;

endpackage : prs_pkg
`default_nettype wire

// [hw/prs_readout_sequencer.sv]
// Readout sequencer for a linear photodiode array preamplifier board
//
// Behaviour
// - A scan starts on a master clock rising edge that samples start high.
// - Exactly one pixel is read per master clock period.
// - End-of-scan output stays high throughout a readout.
// - After the last pixel, end-of-scan is driven low.
// - A 512-pixel scan at the top rate of the fast variant ends within 0.52 ms.
// - The integrator clear input clears the video integrator.
`default_nettype none
`timescale 1ns/1ns
module prs_readout_sequencer #(
  parameter int N_PIXELS = prs_pkg::PIXEL_COUNT,
  parameter bit SLOW_VARIANT = 1'b0
) (
  // System clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Link from the front end controller
  input wire logic i_master_clk,
  input wire logic i_start,
  input wire logic i_integrator_clear,
  // Link back to the controller and the sensor
  output logic o_scan_done_n,
  output logic o_pixel_strobe,
  output logic [$clog2(N_PIXELS)-1:0] o_pixel_index,
  output logic o_integ_clear,
  // System side status
  output logic o_scan_busy,
  output logic o_scan_start_pulse,
  output logic o_scan_end_pulse,
  output logic [prs_pkg::SCAN_CNT_W-1:0] o_scan_count,
  output logic o_overspeed
);

  localparam int IDX_W = $clog2(N_PIXELS);
  localparam logic [IDX_W-1:0] LAST_PIX = IDX_W'(N_PIXELS - 1);
  localparam int MIN_PERIOD_CYC = SLOW_VARIANT ?
    prs_pkg::SLOW_MIN_PERIOD_CYC : prs_pkg::FAST_MIN_PERIOD_CYC;
  localparam logic [prs_pkg::PERIOD_CNT_W-1:0] MIN_PERIOD =
    prs_pkg::PERIOD_CNT_W'(MIN_PERIOD_CYC - 1);
  localparam logic [prs_pkg::PERIOD_CNT_W-1:0] PERIOD_MAX = '1;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  generate
    if (N_PIXELS < 2 || N_PIXELS > 65536) begin : g_bad_pixels
      $error("prs_readout_sequencer: pixel count out of range");
    end
    if (N_PIXELS * prs_pkg::FAST_MIN_PERIOD_NS >
        prs_pkg::SCAN_TIME_NS && N_PIXELS == prs_pkg::PIXEL_COUNT)
    begin : g_bad_scan_time
      $error("prs_readout_sequencer: scan time exceeds budget");
    end
  endgenerate

  // ****************************************************************
  // Link domain reset
  // ****************************************************************
  logic lk_rst_n;

  prs_sync_level #(
    .W(1)
  ) u_lk_rst_sync (
    .i_clk(i_master_clk),
    .i_rst_n(1'b1),
    .i_level(i_resetn),
    .o_level(lk_rst_n)
  );

  // ****************************************************************
  // Integrator clear input
  // ****************************************************************
  logic lk_clear_sync;
  logic next_integ_clear;

  prs_sync_level #(
    .W(1)
  ) u_clear_sync (
    .i_clk(i_master_clk),
    .i_rst_n(lk_rst_n),
    .i_level(i_integrator_clear),
    .o_level(lk_clear_sync)
  );

  always_comb begin
    next_integ_clear = lk_clear_sync;
    if (!lk_rst_n) begin
      next_integ_clear = prs_pkg::INTEG_CLEAR_RST;
    end
  end

  always_ff @(posedge i_master_clk) begin
    o_integ_clear <= next_integ_clear;
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  prs_pkg::prs_state_t state;
  prs_pkg::prs_state_t next_state;
  logic [IDX_W-1:0] next_pixel_index;
  logic next_pixel_strobe;
  logic next_scan_done_n;
  logic lk_start_evt;
  logic lk_end_evt;
  logic lk_rate_tog;
  logic next_rate_tog;

  always_comb begin
    next_state = state;
    next_pixel_index = o_pixel_index;
    next_pixel_strobe = 1'b0;
    next_scan_done_n = o_scan_done_n;
    lk_start_evt = 1'b0;
    lk_end_evt = 1'b0;
    next_rate_tog = ~lk_rate_tog;
    case (state)
      prs_pkg::PRS_IDLE, prs_pkg::PRS_DONE: begin
        if (i_start) begin
          next_state = prs_pkg::PRS_READ;
          next_pixel_index = '0;
          next_pixel_strobe = 1'b1;
          next_scan_done_n = 1'b1;
          lk_start_evt = 1'b1;
        end
      end
      prs_pkg::PRS_READ: begin
        next_scan_done_n = 1'b1;
        if (o_pixel_index == LAST_PIX) begin
          next_state = prs_pkg::PRS_DONE;
          next_scan_done_n = 1'b0;
          lk_end_evt = 1'b1;
        end else begin
          next_pixel_index = o_pixel_index + IDX_W'(1);
          next_pixel_strobe = 1'b1;
        end
      end
      default: begin
        next_state = prs_pkg::PRS_IDLE;
      end
    endcase
    if (!lk_rst_n) begin
      next_state = prs_pkg::PRS_IDLE;
      next_pixel_index = '0;
      next_pixel_strobe = 1'b0;
      next_scan_done_n = prs_pkg::SCAN_DONE_N_RST;
      lk_start_evt = 1'b0;
      lk_end_evt = 1'b0;
      next_rate_tog = 1'b0;
    end
  end

  always_ff @(posedge i_master_clk) begin
    state <= next_state;
    o_pixel_index <= next_pixel_index;
    o_pixel_strobe <= next_pixel_strobe;
    o_scan_done_n <= next_scan_done_n;
    lk_rate_tog <= next_rate_tog;
  end

  // ****************************************************************
  // Crossings into the system domain
  // ****************************************************************
  logic sys_busy_sync;
  logic sys_rate_sync;
  logic sys_start_pulse;
  logic sys_end_pulse;
  logic lk_busy;

  assign lk_busy = (state == prs_pkg::PRS_READ);

  prs_sync_level #(
    .W(2)
  ) u_status_sync (
    .i_clk(i_sys_clk),
    .i_rst_n(i_resetn),
    .i_level({lk_busy, lk_rate_tog}),
    .o_level({sys_busy_sync, sys_rate_sync})
  );

  prs_sync_pulse u_start_xing (
    .i_src_clk(i_master_clk),
    .i_src_rst_n(lk_rst_n),
    .i_src_pulse(lk_start_evt),
    .i_dst_clk(i_sys_clk),
    .i_dst_rst_n(i_resetn),
    .o_dst_pulse(sys_start_pulse)
  );

  prs_sync_pulse u_end_xing (
    .i_src_clk(i_master_clk),
    .i_src_rst_n(lk_rst_n),
    .i_src_pulse(lk_end_evt),
    .i_dst_clk(i_sys_clk),
    .i_dst_rst_n(i_resetn),
    .o_dst_pulse(sys_end_pulse)
  );

  // ****************************************************************
  // System side status
  // ****************************************************************
  logic [prs_pkg::SCAN_CNT_W-1:0] next_scan_count;
  logic next_scan_busy;
  logic next_start_pulse;
  logic next_end_pulse;

  always_comb begin
    next_scan_busy = sys_busy_sync;
    next_start_pulse = sys_start_pulse;
    next_end_pulse = sys_end_pulse;
    next_scan_count = o_scan_count;
    if (sys_end_pulse) begin
      next_scan_count = o_scan_count + prs_pkg::SCAN_CNT_W'(1);
    end
    if (!i_resetn) begin
      next_scan_busy = 1'b0;
      next_start_pulse = 1'b0;
      next_end_pulse = 1'b0;
      next_scan_count = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_scan_busy <= next_scan_busy;
    o_scan_start_pulse <= next_start_pulse;
    o_scan_end_pulse <= next_end_pulse;
    o_scan_count <= next_scan_count;
  end

  // ****************************************************************
  // Master clock rate monitor
  // ****************************************************************
  logic rate_seen;
  logic next_rate_seen;
  logic rate_armed;
  logic next_rate_armed;
  logic rate_edge;
  logic [prs_pkg::PERIOD_CNT_W-1:0] period_cnt;
  logic [prs_pkg::PERIOD_CNT_W-1:0] next_period_cnt;
  logic next_overspeed;

  assign rate_edge = sys_rate_sync ^ rate_seen;

  always_comb begin
    next_rate_seen = sys_rate_sync;
    next_rate_armed = rate_armed;
    next_period_cnt = period_cnt;
    next_overspeed = o_overspeed;
    if (rate_edge) begin
      if (rate_armed && period_cnt < MIN_PERIOD) begin
        next_overspeed = 1'b1;
      end
      next_rate_armed = 1'b1;
      next_period_cnt = prs_pkg::PERIOD_CNT_W'(1);
    end else if (period_cnt != PERIOD_MAX) begin
      next_period_cnt = period_cnt + prs_pkg::PERIOD_CNT_W'(1);
    end
    if (!i_resetn) begin
      next_rate_seen = 1'b0;
      next_rate_armed = 1'b0;
      next_period_cnt = '0;
      next_overspeed = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    rate_seen <= next_rate_seen;
    rate_armed <= next_rate_armed;
    period_cnt <= next_period_cnt;
    o_overspeed <= next_overspeed;
  end

endmodule : prs_readout_sequencer
`default_nettype wire

// [hw/prs_sync_level.sv]
// Two flip-flop level synchroniser
`default_nettype none
`timescale 1ns/1ns
module prs_sync_level #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Level in and out
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  generate
    if (W < 1) begin : g_bad_width
      $error("prs_sync_level: width must be at least one");
    end
  endgenerate

  always_comb begin
    next_stage1 = i_level;
    next_stage2 = stage1;
    if (!i_rst_n) begin
      next_stage1 = '0;
      next_stage2 = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
  end

  assign o_level = stage2;

endmodule : prs_sync_level
`default_nettype wire

// [hw/prs_sync_pulse.sv]
// Toggle based single-pulse crossing between two clock domains
`default_nettype none
`timescale 1ns/1ns
module prs_sync_pulse (
  // Source domain
  input wire logic i_src_clk,
  input wire logic i_src_rst_n,
  input wire logic i_src_pulse,
  // Destination domain
  input wire logic i_dst_clk,
  input wire logic i_dst_rst_n,
  output logic o_dst_pulse
);

  logic src_tog;
  logic next_src_tog;
  logic dst_tog;
  logic dst_seen;
  logic next_dst_seen;
  logic next_pulse;

  // ****************************************************************
  // Source toggle
  // ****************************************************************
  always_comb begin
    next_src_tog = src_tog ^ i_src_pulse;
    if (!i_src_rst_n) begin
      next_src_tog = 1'b0;
    end
  end

  always_ff @(posedge i_src_clk) begin
    src_tog <= next_src_tog;
  end

  // ****************************************************************
  // Destination edge detect
  // ****************************************************************
  prs_sync_level #(
    .W(1)
  ) u_tog_sync (
    .i_clk(i_dst_clk),
    .i_rst_n(i_dst_rst_n),
    .i_level(src_tog),
    .o_level(dst_tog)
  );

  always_comb begin
    next_dst_seen = dst_tog;
    next_pulse = dst_tog ^ dst_seen;
    if (!i_dst_rst_n) begin
      next_dst_seen = 1'b0;
      next_pulse = 1'b0;
    end
  end

  always_ff @(posedge i_dst_clk) begin
    dst_seen <= next_dst_seen;
    o_dst_pulse <= next_pulse;
  end

endmodule : prs_sync_pulse
`default_nettype wire

// [tb/pda_readout_sequencer_tb.sv]
// Self-checking bench of the readout sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pda_readout_sequencer_tb;
  localparam int N = prs_pkg::PIXEL_COUNT;
  logic sys_clk, resetn, done_n, strobe, iclr_out, busy, st_p, end_p, ovs;
  wire mclk, start, iclr;
  logic [$clog2(N)-1:0] idx, exp_idx;
  logic [$clog2(N)-1:0] exp_q[$];
  logic [prs_pkg::SCAN_CNT_W-1:0] scan_cnt;
  int n_fail = 0;
  int cmp_count = 0;
  int n_start = 0;
  int k;
  prs_readout_sequencer dut (.i_sys_clk(sys_clk), .i_resetn(resetn),
    .i_master_clk(mclk), .i_start(start), .i_integrator_clear(iclr),
    .o_scan_done_n(done_n), .o_pixel_strobe(strobe), .o_pixel_index(idx),
    .o_integ_clear(iclr_out), .o_scan_busy(busy), .o_scan_start_pulse(st_p),
    .o_scan_end_pulse(end_p), .o_scan_count(scan_cnt), .o_overspeed(ovs));
  prs_ctl_model u_ctl (.o_master_clk(mclk), .o_start(start),
    .o_integrator_clear(iclr));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pixel monitor against noted indices
  always @(negedge mclk) begin
    if (strobe === 1'b1) begin
      `CHK("pending", 1'b1, exp_q.size() > 0)
      exp_idx = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      `CHK("index", exp_idx, idx)
      `CHK("done_n in scan", 1'b1, done_n)
    end
  end
  always @(negedge sys_clk) begin
    if (st_p === 1'b1) n_start++;
  end
  task automatic run_scan(input int hold);
    int i;
    for (i = 0; i < N; i++) exp_q.push_back(i[$clog2(N)-1:0]);
    u_ctl.scan(hold);
    repeat (8) @(posedge sys_clk);
    #1 `CHK("busy in scan", 1'b1, busy)
    for (i = 0; i < 700 && done_n !== 1'b0; i++) @(negedge mclk);
    `CHK("done_n end", 1'b0, done_n)
    `CHK("pixels left", 0, exp_q.size())
  endtask : run_scan
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    n_fail++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h98ee));
    resetn = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 resetn = 1'b1;
    `CHK("reset done_n", 1'b1, done_n)
    repeat (10) @(posedge mclk);
    u_ctl.rand_clr = 1'b1;
    for (k = 0; k < 3; k++) begin
      run_scan(k == 0 ? 1 : int'($urandom_range(2, 100)));
      $display("test scan %0d done", k);
    end
    repeat (10) @(posedge sys_clk);
    #1 `CHK("scan count", 16'h0003, scan_cnt)
    `CHK("starts", 3, n_start)
    `CHK("busy", 1'b0, busy)
    `CHK("overspeed", 1'b1, ovs)
    finish_test();
  end
endmodule : pda_readout_sequencer_tb
`default_nettype wire

// [tb/prs_asserts.sv]
// Port checker of the readout sequencer
`timescale 1ns/1ns
`default_nettype none
module prs_asserts #(
  parameter int N_PIXELS = 512
) (
  // Clocks and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_master_clk,
  // Link inputs
  input wire logic i_start,
  input wire logic i_integrator_clear,
  // Watched outputs
  input wire logic o_scan_done_n,
  input wire logic o_pixel_strobe,
  input wire logic [$clog2(N_PIXELS)-1:0] o_pixel_index,
  input wire logic o_integ_clear,
  input wire logic o_scan_end_pulse,
  input wire logic [prs_pkg::SCAN_CNT_W-1:0] o_scan_count
);
  logic [15:0] pix_cnt;
  // ****************************************
  // Strobe cycle counter
  // ****************************************
  always_ff @(posedge i_master_clk) begin
    pix_cnt <= o_pixel_strobe ? pix_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_first;
    o_pixel_strobe && o_pixel_index == '0 && o_scan_done_n;
  endsequence
  sequence s_tail;
    !o_pixel_strobe && !o_scan_done_n;
  endsequence
  property p_launch;
    @(posedge i_master_clk) disable iff (!i_resetn)
    i_start && !o_pixel_strobe |=> s_first;
  endproperty
  property p_step;
    @(posedge i_master_clk) disable iff (!i_resetn)
    o_pixel_strobe && o_pixel_index != N_PIXELS - 1 |=>
      o_pixel_strobe && o_pixel_index == $past(o_pixel_index) + 1'b1;
  endproperty
  property p_last;
    @(posedge i_master_clk) disable iff (!i_resetn)
    o_pixel_strobe && o_pixel_index == N_PIXELS - 1 |=> s_tail;
  endproperty
  property p_high;
    @(posedge i_master_clk) disable iff (!i_resetn)
    o_pixel_strobe |-> o_scan_done_n;
  endproperty
  property p_hold;
    @(posedge i_master_clk) disable iff (!i_resetn)
    !o_scan_done_n && !i_start |=> s_tail;
  endproperty
  property p_len;
    @(posedge i_master_clk) disable iff (!i_resetn)
    $fell(o_pixel_strobe) |-> pix_cnt == N_PIXELS;
  endproperty
  property p_clr;
    @(posedge i_master_clk) disable iff (!i_resetn)
    o_integ_clear == $past(i_integrator_clear, 3);
  endproperty
  property p_count;
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_scan_end_pulse) |->
      o_scan_count - $past(o_scan_count) == 16'h0001 ##1 !o_scan_end_pulse;
  endproperty
  a_launch: assert property (p_launch) else $error("launch wrong");
  a_step: assert property (p_step) else $error("index step wrong");
  a_last: assert property (p_last) else $error("end not marked");
  a_high: assert property (p_high) else $error("done low in scan");
  a_hold: assert property (p_hold) else $error("done left early");
  a_len: assert property (p_len) else $error("scan length wrong");
  a_clr: assert property (p_clr) else $error("clear not passed");
  a_count: assert property (p_count) else $error("count wrong");
endmodule : prs_asserts
bind prs_readout_sequencer prs_asserts #(.N_PIXELS(N_PIXELS)) u_asserts (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_master_clk(i_master_clk),
  .i_start(i_start), .i_integrator_clear(i_integrator_clear),
  .o_scan_done_n(o_scan_done_n), .o_pixel_strobe(o_pixel_strobe),
  .o_pixel_index(o_pixel_index), .o_integ_clear(o_integ_clear),
  .o_scan_end_pulse(o_scan_end_pulse), .o_scan_count(o_scan_count));
`default_nettype wire

// [tb/prs_ctl_model.sv]
// Front end controller model: master clock, start, integrator clear
`timescale 1ns/1ns
`default_nettype none
module prs_ctl_model (
  // Link to the board
  output logic o_master_clk,
  output logic o_start,
  output logic o_integrator_clear
);
  bit rand_clr = 1'b0;
  initial begin
    o_master_clk = 1'b0;
    o_start = 1'b0;
    forever #6 o_master_clk = ~o_master_clk;
  end
  // Random integrator clear level once enabled
  initial o_integrator_clear = 1'b0;
  always @(posedge o_master_clk) begin
    o_integrator_clear <= #1 rand_clr & 1'($urandom_range(0, 1));
  end
  // Start held high across hold edges
  task automatic scan(input int hold);
    @(posedge o_master_clk);
    #1 o_start = 1'b1;
    repeat (hold) @(posedge o_master_clk);
    #1 o_start = 1'b0;
  endtask : scan
endmodule : prs_ctl_model
`default_nettype wire
